//--- include/wdr_pkg.sv
package wdr_pkg;
   // register offsets
   localparam logic [7:0] ADDR_CTRL = 8'h21;
   localparam logic [7:0] ADDR_CAUSE = 8'h34;
   // control register field positions
   localparam int B_IF = 7;
   localparam int B_IE = 6;
   localparam int B_P3 = 5;
   localparam int B_CE = 4;
   localparam int B_EN = 3;
   localparam int B_P2 = 2;
   // reset-cause field positions
   localparam int B_WRF = 3;
   localparam int B_BRF = 2;
   localparam int B_XRF = 1;
   localparam int B_PRF = 0;
   // reset values
   localparam logic [3:0] CAUSE_RST = 4'h1;
   localparam logic [3:0] TSEL_RST = 4'h0;
   // change window length in clock cycles
   localparam int CE_CYCLES = 4;
   localparam logic [1:0] CE_LOAD = 2'(CE_CYCLES - 1);
   // prescaler width and highest usable tap
   localparam int PS_W = 24;
   localparam logic [3:0] TSEL_MAX = 4'h9;
   localparam int TAP_BASE_DEF = 11;
endpackage

//--- hdl/wdr_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module wdr_prescaler #(
   parameter int BASE = wdr_pkg::TAP_BASE_DEF
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, low
   input wire logic run, // count enable
   input wire logic restart, // clear the count
   input wire logic [3:0] sel, // time-out select
   output logic tmo // one-cycle time-out
);
   typedef struct packed {
      logic [wdr_pkg::PS_W-1:0] cnt;
      logic tmo;
   } wdr_ps_t;
   wdr_ps_t q;
   wdr_ps_t n;

   // last count of the selected tap
   function automatic logic [wdr_pkg::PS_W-1:0] tap_end(input logic [3:0] s);
      logic [3:0] c;
      c = (s > wdr_pkg::TSEL_MAX) ? wdr_pkg::TSEL_MAX : s;
      tap_end = (wdr_pkg::PS_W'(1) << (BASE + int'(c))) - wdr_pkg::PS_W'(1);
   endfunction

   always_comb begin
      n = q;
      n.tmo = 1'b0;
      if (restart) begin
         n.cnt = '0;
      end else if (run) begin
         if (q.cnt >= tap_end(sel)) begin
            n.cnt = '0;
            n.tmo = 1'b1;
         end else begin
            n.cnt = q.cnt + wdr_pkg::PS_W'(1);
         end
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign tmo = q.tmo;
endmodule
`default_nettype wire

//--- hdl/wdr_rstflags.sv
`timescale 1ns/10ps
`default_nettype none
module wdr_rstflags (
   input wire logic clk, // system clock
   input wire logic rst_n, // power-on reset, low
   input wire logic wr, // write to cause register
   input wire logic [3:0] wdata, // write data
   input wire logic wdt_evt, // watchdog reset pulse
   input wire logic bor_evt, // brown-out reset pulse
   input wire logic ext_evt, // pin reset pulse
   output logic [3:0] flags // reset-cause flags
);
   typedef struct packed {
      logic [3:0] f;
   } wdr_rf_t;
   wdr_rf_t q;
   wdr_rf_t n;

   // clears by writing zero, sets win over clears
   always_comb begin
      n = q;
      if (wr) begin
         n.f = q.f & wdata;
      end
      n.f[wdr_pkg::B_WRF] = n.f[wdr_pkg::B_WRF] | wdt_evt;
      n.f[wdr_pkg::B_BRF] = n.f[wdr_pkg::B_BRF] | bor_evt;
      n.f[wdr_pkg::B_XRF] = n.f[wdr_pkg::B_XRF] | ext_evt;
   end

   // power-on leaves only the power-on flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q.f <= wdr_pkg::CAUSE_RST;
      end else begin
         q <= n;
      end
   end

   assign flags = q.f;
endmodule
`default_nettype wire

//--- hdl/wdr_top.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module wdr_top #(
   parameter int TAP_BASE = wdr_pkg::TAP_BASE_DEF
) (
   input wire logic MCLK, // 100 MHz system clock
   input wire logic RST_N, // power-on reset, low
   input wire logic [7:0] ADDR, // register address
   input wire logic [7:0] WDATA, // write data
   input wire logic WR, // write strobe
   input wire logic RD, // read strobe
   output logic [7:0] RDATA, // read data, next cycle
   input wire logic SAFETY_FUSE, // 1 = fuse programmed
   input wire logic WDR_KICK, // restart the count
   input wire logic GIE_BIT, // global irq enable
   input wire logic IRQ_ACK, // vector being entered
   input wire logic BOR_EVENT, // brown-out reset pulse
   input wire logic EXT_EVENT, // pin reset pulse
   output logic WDT_IRQ, // time-out irq request
   output logic WDT_RESET // watchdog reset pulse
);
   typedef struct packed {
      logic init_done;
      logic lvl2;
      logic timeout_irq_flag;
      logic timeout_irq_enable;
      logic watchdog_enable_bit;
      logic [3:0] timeout_select_bits;
      logic ce;
      logic [1:0] ce_cnt;
      logic irq_arm;
      logic rst_pulse;
      logic [7:0] rdata;
   } wdr_ctl_t;
   wdr_ctl_t q;
   wdr_ctl_t n;

   logic wr_ctl;
   logic rd_ctl;
   logic wr_cause;
   logic rd_cause;
   logic sys_rst;
   logic tmo;
   logic wde_eff;
   logic run;
   logic [3:0] flags;
   logic [7:0] ctrl_rd;

   // register address match
   function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
      reg_hit = (a == off);
   endfunction

   // address decode
   assign wr_ctl = WR && reg_hit(ADDR, wdr_pkg::ADDR_CTRL);
   assign rd_ctl = RD && reg_hit(ADDR, wdr_pkg::ADDR_CTRL);
   assign wr_cause = WR && reg_hit(ADDR, wdr_pkg::ADDR_CAUSE);
   assign rd_cause = RD && reg_hit(ADDR, wdr_pkg::ADDR_CAUSE);

   // any system reset other than power-on
   assign sys_rst = q.rst_pulse | BOR_EVENT | EXT_EVENT;

   assign wde_eff = q.lvl2 | q.watchdog_enable_bit | flags[wdr_pkg::B_WRF];

   assign run = wde_eff | q.timeout_irq_enable;

   // control register as software sees it
   assign ctrl_rd = {q.timeout_irq_flag, q.timeout_irq_enable, q.timeout_select_bits[3], q.ce, wde_eff, q.timeout_select_bits[2:0]};

   // reset-cause flags
   wdr_rstflags u_flags (
      .clk(MCLK),
      .rst_n(RST_N),
      .wr(wr_cause),
      .wdata(WDATA[3:0]),
      .wdt_evt(q.rst_pulse),
      .bor_evt(BOR_EVENT),
      .ext_evt(EXT_EVENT),
      .flags(flags)
   );

   // time-out counter
   wdr_prescaler #(
      .BASE(TAP_BASE)
   ) u_presc (
      .clk(MCLK),
      .rst_n(RST_N),
      .run(run),
      .restart(WDR_KICK | sys_rst | ~run),
      .sel(q.timeout_select_bits),
      .tmo(tmo)
   );

   // next state of the control logic
   always_comb begin
      n = q;
      n.rst_pulse = 1'b0;
      n.rdata = 8'h00;
      if (!q.init_done) begin
         n.init_done = 1'b1;
         n.lvl2 = SAFETY_FUSE;
         n.watchdog_enable_bit = SAFETY_FUSE;
      end
      if (q.ce) begin
         if (q.ce_cnt == 2'h0) begin
            n.ce = 1'b0;
         end else begin
            n.ce_cnt = q.ce_cnt - 2'h1;
         end
      end
      if (wr_ctl) begin
         if (WDATA[wdr_pkg::B_IF]) begin
            n.timeout_irq_flag = 1'b0;
            n.irq_arm = 1'b0;
         end
         n.timeout_irq_enable = WDATA[wdr_pkg::B_IE];
         if (WDATA[wdr_pkg::B_EN]) begin
            n.watchdog_enable_bit = 1'b1;
         end else if (q.ce && !q.lvl2) begin
            n.watchdog_enable_bit = 1'b0;
         end
         if (!q.lvl2 || q.ce) begin
            n.timeout_select_bits = {WDATA[wdr_pkg::B_P3], WDATA[wdr_pkg::B_P2:0]};
         end
         if (WDATA[wdr_pkg::B_CE] && WDATA[wdr_pkg::B_EN]) begin
            n.ce = 1'b1;
            n.ce_cnt = wdr_pkg::CE_LOAD;
         end else if (!WDATA[wdr_pkg::B_CE]) begin
            n.ce = 1'b0;
         end
      end
      if (IRQ_ACK) begin
         n.timeout_irq_flag = 1'b0;
         n.irq_arm = 1'b0;
      end
      // time-out, after the clears so a set wins
      if (tmo) begin
         if (q.timeout_irq_enable) begin
            n.timeout_irq_flag = 1'b1;
            if (wde_eff) begin
               n.timeout_irq_enable = 1'b0;
               n.irq_arm = 1'b1;
            end
         end else if (wde_eff) begin
            n.rst_pulse = 1'b1;
         end
      end
      // a system reset restores the control register
      if (sys_rst) begin
         n.timeout_irq_flag = 1'b0;
         n.timeout_irq_enable = 1'b0;
         n.timeout_select_bits = wdr_pkg::TSEL_RST;
         n.ce = 1'b0;
         n.irq_arm = 1'b0;
         n.watchdog_enable_bit = q.lvl2;
      end
      // reset flag holds enable, so a disable tried meanwhile is lost
      if (flags[wdr_pkg::B_WRF]) begin
         n.watchdog_enable_bit = 1'b1;
      end
      // read data for the next cycle
      if (rd_ctl) begin
         n.rdata = ctrl_rd;
      end else if (rd_cause) begin
         n.rdata = {4'h0, flags};
      end
   end

   // state register
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign WDT_IRQ = q.timeout_irq_flag & GIE_BIT & (q.timeout_irq_enable | q.irq_arm);
   assign WDT_RESET = q.rst_pulse;
   assign RDATA = q.rdata;

   // checks on the control logic
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_N);

   // window opened by a write of both ones
   sequence seq_ce_open;
      wr_ctl && WDATA[wdr_pkg::B_CE] && WDATA[wdr_pkg::B_EN] && !sys_rst;
   endsequence

   // a cycle with no control write and no reset
   sequence seq_quiet;
      !wr_ctl && !sys_rst;
   endsequence

   chk_fuse_level: assert property (
      $rose(q.init_done) |-> (q.lvl2 == $past(SAFETY_FUSE)) && (wde_eff == $past(SAFETY_FUSE))
   ) else $error("safety level not taken from fuse");

   chk_enable_set: assert property (
      wr_ctl && WDATA[wdr_pkg::B_EN] && !sys_rst |=> q.watchdog_enable_bit
   ) else $error("enable write of one not taken");

   chk_window_open: assert property (
      seq_ce_open ##1 seq_quiet [*3] |-> q.ce
   ) else $error("change window shut too early");

   chk_window_close: assert property (
      seq_ce_open ##1 seq_quiet [*4] |=> !q.ce
   ) else $error("change window open too long");

   chk_level2_read: assert property (
      rd_ctl && q.lvl2 |=> RDATA[wdr_pkg::B_EN]
   ) else $error("enable not read as one in level 2");

   chk_level2_hold: assert property (
      q.lvl2 && q.watchdog_enable_bit |=> q.watchdog_enable_bit
   ) else $error("watchdog disabled in level 2");

   chk_select_guard: assert property (
      wr_ctl && q.lvl2 && !q.ce && !sys_rst |=> $stable(q.timeout_select_bits)
   ) else $error("select changed without window");

   chk_enable_hold: assert property (
      wr_ctl && !WDATA[wdr_pkg::B_EN] && !q.ce && q.watchdog_enable_bit && !sys_rst |=> q.watchdog_enable_bit
   ) else $error("enable cleared without window");

   chk_tmo_reset: assert property (
      tmo && !q.timeout_irq_enable && wde_eff |=> WDT_RESET ##1 !WDT_RESET
   ) else $error("time-out did not give one reset pulse");

   chk_tmo_irq: assert property (
      tmo && q.timeout_irq_enable && !sys_rst |=> q.timeout_irq_flag && !WDT_RESET
   ) else $error("time-out did not raise the flag");

   chk_irqen_clear: assert property (
      tmo && q.timeout_irq_enable && wde_eff && !sys_rst |=> !q.timeout_irq_enable
   ) else $error("irq enable kept after time-out");

   chk_flag_ack: assert property (
      IRQ_ACK && !tmo && !sys_rst |=> !q.timeout_irq_flag && !WDT_IRQ
   ) else $error("flag kept after vector entry");

   chk_force_enable: assert property (
      rd_ctl && flags[wdr_pkg::B_WRF] |=> RDATA[wdr_pkg::B_EN]
   ) else $error("enable not forced by reset flag");

   chk_watchdog_reset_flag_set: assert property (
      WDT_RESET |=> flags[wdr_pkg::B_WRF]
   ) else $error("watchdog reset flag not set");

   chk_reserved_zero: assert property (
      rd_cause |=> RDATA[7:4] == 4'h0
   ) else $error("reserved cause bits not zero");

   chk_window_set: assert property (
      seq_ce_open |=> q.ce
   ) else $error("change window not opened");

   chk_tmo_irq_only: assert property (
      tmo && q.timeout_irq_enable && !wde_eff && !wr_ctl && !sys_rst |=> q.timeout_irq_enable && !WDT_RESET
   ) else $error("interrupt mode left after time-out");

   chk_stopped_quiet: assert property (
      !run |=> !WDT_RESET
   ) else $error("reset from a stopped watchdog");

   chk_write_clear: assert property (
      wr_ctl && WDATA[wdr_pkg::B_IF] && !tmo |=> !q.timeout_irq_flag
   ) else $error("flag kept after write of one");

   chk_irq_request: assert property (
      tmo && q.timeout_irq_enable && !sys_rst |=> WDT_IRQ == GIE_BIT
   ) else $error("time-out irq request wrong");

   chk_irq_mask: assert property (
      !GIE_BIT || !q.timeout_irq_flag |-> !WDT_IRQ
   ) else $error("irq requested while masked");

   chk_force_hold: assert property (
      flags[wdr_pkg::B_WRF] |=> q.watchdog_enable_bit
   ) else $error("enable bit not held by reset flag");

   chk_watchdog_reset_flag_clear: assert property (
      wr_cause && !WDATA[wdr_pkg::B_WRF] && !WDT_RESET |=> !flags[wdr_pkg::B_WRF]
   ) else $error("watchdog reset flag not cleared");

   chk_bor_set: assert property (
      BOR_EVENT |=> flags[wdr_pkg::B_BRF]
   ) else $error("brown-out flag not set");

   chk_bor_clear: assert property (
      wr_cause && !WDATA[wdr_pkg::B_BRF] && !BOR_EVENT |=> !flags[wdr_pkg::B_BRF]
   ) else $error("brown-out flag not cleared");

   chk_ext_set: assert property (
      EXT_EVENT |=> flags[wdr_pkg::B_XRF]
   ) else $error("pin reset flag not set");

   chk_ext_clear: assert property (
      wr_cause && !WDATA[wdr_pkg::B_XRF] && !EXT_EVENT |=> !flags[wdr_pkg::B_XRF]
   ) else $error("pin reset flag not cleared");

   chk_por_hold: assert property (
      !(wr_cause && !WDATA[wdr_pkg::B_PRF]) |=> $stable(flags[wdr_pkg::B_PRF])
   ) else $error("power-on flag changed without zero write");

   chk_por_clear: assert property (
      wr_cause && !WDATA[wdr_pkg::B_PRF] |=> !flags[wdr_pkg::B_PRF]
   ) else $error("power-on flag not cleared");
endmodule
`default_nettype wire

//--- dv/wdr_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module wdr_top_tb;
   logic MCLK = 0, RST_N = 0, WR = 0, RD = 0, SAFETY_FUSE = 0, WDR_KICK = 1;
   logic GIE_BIT = 0, IRQ_ACK = 0, BOR_EVENT = 0, EXT_EVENT = 0, WDT_IRQ, WDT_RESET;
   logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, d;
   logic [3:0] cause, sel;
   int n_fail = 0, n_compared = 0, n_rst = 0, seed = 27863;

   // short prescaler taps keep time-outs within a few hundred cycles
   wdr_top #(.TAP_BASE(2)) DUT (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .SAFETY_FUSE(SAFETY_FUSE), .WDR_KICK(WDR_KICK), .GIE_BIT(GIE_BIT), .IRQ_ACK(IRQ_ACK),
      .BOR_EVENT(BOR_EVENT), .EXT_EVENT(EXT_EVENT), .WDT_IRQ(WDT_IRQ), .WDT_RESET(WDT_RESET));

   // 100 MHz clock and a count of watchdog reset pulses
   always #5 MCLK = ~MCLK;
   always @(posedge MCLK) if (WDT_RESET === 1'b1) n_rst <= n_rst + 1;

   // expected control byte for a plain select and enable value
   function automatic logic [7:0] ctl(input logic [3:0] s, input logic en);
      return {2'b00, s[3], 1'b0, en, s[2:0]};
   endfunction

   // flags after reset events, then a software write (zero clears, one keeps)
   function automatic logic [3:0] cause_upd(input logic [3:0] c, input logic [7:0] v);
      return (c | {1'b0, v[4], v[5], 1'b0}) & v[3:0];
   endfunction

   task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one bus cycle, launched just after a rising edge
   task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] v);
      @(posedge MCLK);
      WR <= w;
      RD <= r;
      ADDR <= a;
      WDATA <= v;
   endtask

   task automatic idle(input int n);
      repeat (n) cyc(1'b0, 1'b0, 8'h00, 8'h00);
   endtask

   task automatic wr(input bit c, input logic [7:0] v);
      cyc(1'b1, 1'b0, c ? wdr_pkg::ADDR_CAUSE : wdr_pkg::ADDR_CTRL, v);
   endtask

   // read data are looked at in the one cycle after the strobe
   task automatic rd(input bit c, input string nm, input logic [7:0] exp);
      cyc(1'b0, 1'b1, c ? wdr_pkg::ADDR_CAUSE : wdr_pkg::ADDR_CTRL, 8'h00);
      idle(1);
      #1;
      chk8(nm, exp, RDATA);
   endtask

   // bounded wait for the reset pulse or the interrupt request
   task automatic wait_hi(input bit rst, input int lim);
      int i;
      i = 0;
      idle(1);
      do begin
         @(posedge MCLK);
         #1;
         i++;
      end while (((rst ? WDT_RESET : WDT_IRQ) !== 1'b1) && i < lim);
      chk8(rst ? "reset pulse" : "irq request", 8'h01, {7'h00, rst ? WDT_RESET : WDT_IRQ});
   endtask

   task automatic do_reset(input logic fuse);
      @(posedge MCLK);
      RST_N <= 1'b0;
      SAFETY_FUSE <= fuse;
      repeat (12) @(posedge MCLK);
      RST_N <= 1'b1;
      idle(1);
   endtask

   task automatic tally_and_finish();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // hang guard at 10000 cycles, far beyond the thousand or so cycles the run needs
   initial begin
      #100000;
      n_fail++;
      tally_and_finish();
   end

   // main sequence
   initial begin
      do_reset(1'b0);
      rd(0, "ctrl", 8'h00);
      rd(1, "cause", 8'h01);
      cyc(1'b1, 1'b0, 8'h22, 8'hff);
      cyc(1'b0, 1'b1, 8'h22, 8'h00);
      idle(1);
      #1;
      chk8("unmapped", 8'h00, RDATA);
      // stopped watchdog does nothing
      WDR_KICK <= 1'b0;
      idle(100);
      chk8("stopped resets", 8'h00, 8'(n_rst));
      rd(0, "stopped ctrl", 8'h00);
      WDR_KICK <= 1'b1;
      // random reset events against random flag writes
      cause = 4'h1;
      repeat (8) begin
         d = 8'($random(seed));
         BOR_EVENT <= d[4];
         EXT_EVENT <= d[5];
         idle(1);
         BOR_EVENT <= 1'b0;
         EXT_EVENT <= 1'b0;
         wr(1, d);
         cause = cause_upd(cause, d);
         rd(1, "cause", {4'h0, cause});
      end
      // a brown-out in the cycle of a clearing write keeps its flag
      wr(1, 8'h00);
      BOR_EVENT <= 1'b1;
      idle(1);
      BOR_EVENT <= 1'b0;
      rd(1, "set beats clear", 8'h04);
      wr(1, 8'h00);
      // level 1 enables and changes select freely
      repeat (6) begin
         sel = 4'($unsigned($random(seed)) % 10);
         wr(0, ctl(sel, 1'b1));
         rd(0, "enable select", ctl(sel, 1'b1));
      end
      wr(0, 8'h00);
      rd(0, "no window", 8'h08);
      wr(0, 8'h18);
      rd(0, "window open", 8'h18);
      idle(3);
      rd(0, "window closed", 8'h08);
      wr(0, 8'h18);
      idle(4);
      wr(0, 8'h00);
      rd(0, "late disable", 8'h08);
      wr(0, 8'h18);
      idle(3);
      wr(0, 8'h05);
      rd(0, "timed disable", 8'h05);
      // interrupt only mode, masked then unmasked
      WDR_KICK <= 1'b0;
      wr(0, 8'h45);
      idle(150);
      #1;
      chk8("masked irq", 8'h00, {7'h00, WDT_IRQ});
      rd(0, "irq flag", 8'hc5);
      GIE_BIT <= 1'b1;
      idle(1);
      #1;
      chk8("irq", 8'h01, {7'h00, WDT_IRQ});
      IRQ_ACK <= 1'b1;
      idle(1);
      IRQ_ACK <= 1'b0;
      #1;
      chk8("irq ack", 8'h00, {7'h00, WDT_IRQ});
      wait_hi(0, 200);
      wr(0, 8'hc5);
      idle(1);
      #1;
      chk8("irq write clear", 8'h00, {7'h00, WDT_IRQ});
      // interrupt first, then reset
      wr(0, 8'h4d);
      wait_hi(0, 200);
      rd(0, "irq enable auto clear", 8'h8d);
      wait_hi(1, 200);
      WDR_KICK <= 1'b1;
      rd(1, "wd reset flag", 8'h08);
      rd(0, "forced enable", 8'h08);
      wr(0, 8'h18);
      wr(0, 8'h00);
      rd(0, "flag blocks disable", 8'h08);
      wr(1, 8'h00);
      rd(1, "flag cleared", 8'h00);
      rd(0, "enable held", 8'h08);
      wr(0, 8'h18);
      wr(0, 8'h00);
      rd(0, "disable after clear", 8'h00);
      // level 2
      do_reset(1'b1);
      rd(0, "level 2 ctrl", 8'h08);
      rd(1, "cause", 8'h01);
      wr(0, 8'h03);
      rd(0, "select locked", 8'h08);
      wr(0, 8'h18);
      wr(0, 8'h00);
      rd(0, "disable ignored", 8'h08);
      wr(0, 8'h18);
      wr(0, 8'h0b);
      rd(0, "timed select", 8'h0b);
      WDR_KICK <= 1'b0;
      wait_hi(1, 200);
      tally_and_finish();
   end
endmodule
`default_nettype wire
